// [core/level_sync.sv]
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : level_sync

// [core/servo_status_output_flags.sv]
// Status output flag generator of a servo drive unit
//
// Behaviour
// R1: Malfunction flag drops whenever the protective circuit shuts off base drive.
// R2: With no alarm, malfunction flag rises 2.5-3.5 s (multi-axis 3.5-4.0 s) after power-on.
// R3: In-position flag set while droop count lies within the in-position range.
// R4: In-position flag offered only in position control.
// R5: Ready flag rises when the drive enters servo-on.
// R6: Speed-reached low at servo-off; high within set speed +/- (set*0.05+20).
// R7: Speed-reached always high when set speed is 20 or less.
// R8: Speed-reached offered only in velocity control.
// R9: Warning flag high on any warning; else settles low in power-on window.
// R10: Battery warning high on warning 092 or 09F; else settles low.
// R11: Battery warning always low with a battery-less absolute encoder.
// R12: Motor-stop warning high on a drive-preventing warning; else settles low.
// R13: Gain-switch indicators follow the first and second switched gain sets.
// R14: Absolute-position-lost flag high while absolute position is undetermined.
// R15: Fully-closed-loop indicator high in fully closed loop, low in semi closed.
// R16: Converter flag set on ready-on command, cleared by converter-stopping alarm.
// R17: Brake interlock low at servo-off and on any alarm.
// R18: Speed-limiting flag in torque mode only, low at servo-off.
// R19: Zero-speed flag rises when speed magnitude reaches the zero-speed level.
// R20: Zero-speed flag clears only at level plus 20 r/min hysteresis.
// R21: Torque-limiting flag on torque limit, low at servo-off and in torque mode.
// R22: All flags registered and held deasserted during reset and settling; the three warning flags are not held low while settling.
`timescale 1ns/1ps
`include "status_flags_regs.svh"
module servo_status_output_flags
    import status_flags_pkg::*;
#(
    parameter int SPW           = 16,
    parameter int DPW           = 24,
    parameter int SETTLE_SINGLE = `SETTLE_SINGLE_CYC,
    parameter int SETTLE_MULTI  = `SETTLE_MULTI_CYC
) (
    input  wire logic           clk_sys,
    input  wire logic           rstn,
    // Configuration
    input  wire logic           multi_axis,
    input  wire logic [1:0]     ctrl_mode,
    input  wire logic           batteryless_abs,
    input  wire logic [DPW-1:0] in_position_range_setting,
    input  wire logic [SPW-1:0] zero_speed_level_setting,
    // Drive state from the same clock domain
    input  wire logic           base_shutoff,
    input  wire logic           alarm_active,
    input  wire logic           conv_stop_alarm,
    input  wire logic           warning_active,
    input  wire logic [11:0]    warning_code,
    input  wire logic           stop_warning_active,
    input  wire logic           servo_on,
    input  wire logic [DPW-1:0] droop_mag,
    input  wire logic [SPW-1:0] set_speed,
    input  wire logic [SPW-1:0] speed_mag,
    input  wire logic           speed_at_limit,
    input  wire logic           torque_at_limit,
    input  wire logic           gain_set1_active,
    input  wire logic           gain_set2_active,
    input  wire logic           abs_pos_valid,
    input  wire logic           closed_loop_full,
    // Asynchronous command from the converter link
    input  wire logic           ready_on_cmd,
    // Flags
    output logic                malfunction_flag,
    output logic                in_position_flag,
    output logic                ready_flag,
    output logic                speed_reached_flag,
    output logic                warning_flag,
    output logic                battery_warning_flag,
    output logic                motor_stop_warning_flag,
    output logic                gain_switch_indicator,
    output logic                gain_switch_indicator_second,
    output logic                abs_position_lost_flag,
    output logic                tough_drive_flag,
    output logic                fully_closed_loop_indicator,
    output logic                converter_status_flag,
    output logic                brake_interlock_flag,
    output logic                speed_limiting_flag,
    output logic                zero_speed_flag,
    output logic                torque_limiting_flag
);

    // ------------------------------------------------------------
    // Power-on settling
    // ------------------------------------------------------------
    settle_state_t settle_r;
    logic [31:0]   settle_cnt_r;
    logic [31:0]   settle_limit;
    logic          settled;
    logic          settle_done;

    // Window start is the earliest legal point; shortest power-up wait
    assign settle_limit = multi_axis ? 32'(SETTLE_MULTI) : 32'(SETTLE_SINGLE);
    assign settled      = (settle_r == ST_RUN);
    assign settle_done  = (settle_cnt_r >= settle_limit - 32'h0000_0001);

    // Counter freezes once done, so it can never wrap back
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_cnt_r <= 32'h0000_0000;
        end else if (settle_r == ST_SETTLING && !settle_done) begin
            settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            settle_r <= ST_SETTLING;
        end else begin
            case (settle_r)
                ST_SETTLING: begin
                    if (settle_done) begin
                        settle_r <= ST_RUN;                      // [R22]
                    end
                end
                ST_RUN:  settle_r <= ST_RUN;
                default: settle_r <= ST_SETTLING;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Input crossing
    // ------------------------------------------------------------
    logic ready_on_s;

    level_sync #(
        .WIDTH (1)
    ) u_ready_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (ready_on_cmd),
        .dout    (ready_on_s)
    );

    logic ready_on_d_r;
    logic ready_on_rise;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ready_on_d_r <= 1'b0;
        end else begin
            ready_on_d_r <= ready_on_s;
        end
    end

    assign ready_on_rise = ready_on_s && !ready_on_d_r;

    // ------------------------------------------------------------
    // Speed comparisons
    // ------------------------------------------------------------
    function automatic logic [SPW+1:0] absdiff(input logic [SPW-1:0] a,
                                               input logic [SPW-1:0] b);
        absdiff = (a >= b) ? (SPW+2)'(a - b) : (SPW+2)'(b - a);
    endfunction : absdiff

    logic [SPW+1:0] sa_band;
    logic           sa_hit;
    logic           pos_mode;
    logic           vel_mode;
    logic           trq_mode;

    assign pos_mode = (ctrl_mode == MODE_POSITION);
    assign vel_mode = (ctrl_mode == MODE_VELOCITY);
    assign trq_mode = (ctrl_mode == MODE_TORQUE);
    // Integer 5 % keeps the band free of a divider-free rounding surprise
    assign sa_band  = (SPW+2)'((32'(set_speed) * `SA_PCT) / 100 + `SA_OFFSET);
    assign sa_hit   = (set_speed <= SPW'(`SA_MIN_SET))                // [R7]
                   || (absdiff(speed_mag, set_speed) <= sa_band);    // [R6]

    logic zsp_raw;

    zero_speed_det #(
        .SPW (SPW)
    ) u_zsp (
        .clk_sys                  (clk_sys),
        .rstn                     (rstn),
        .enable                   (settled),
        .speed_mag                (speed_mag),
        .zero_speed_level_setting (zero_speed_level_setting),
        .zero_speed               (zsp_raw)
    );

    // ------------------------------------------------------------
    // Alarm and warning flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            malfunction_flag <= 1'b0;                            // [R22]
        end else begin
            // Low until settled, then high only with no alarm or shutoff
            malfunction_flag <= settled && !alarm_active && !base_shutoff; // [R1] [R2]
        end
    end

    // Warnings pass at once: a high means something even while settling
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            warning_flag            <= 1'b0;
            battery_warning_flag    <= 1'b0;
            motor_stop_warning_flag <= 1'b0;
        end else begin
            warning_flag     <= warning_active;                           // [R9]
            battery_warning_flag <= !batteryless_abs && warning_active     // [R11]
                && (warning_code == `WARN_BATT_CABLE
                    || warning_code == `WARN_BATT_LOW);                   // [R10]
            motor_stop_warning_flag <= stop_warning_active;               // [R12]
        end
    end

    // ------------------------------------------------------------
    // Motion flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            in_position_flag <= 1'b0;
            ready_flag       <= 1'b0;
        end else begin
            in_position_flag <= settled && pos_mode                      // [R4]
                && (droop_mag <= in_position_range_setting);            // [R3]
            ready_flag <= settled && servo_on;                          // [R5]
        end
    end

    // ------------------------------------------------------------
    // Speed and limit flags
    // ------------------------------------------------------------
    // Speed-reached and speed-limiting flags only in their own mode; torque limiting in every mode but torque
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            speed_reached_flag   <= 1'b0;
            speed_limiting_flag  <= 1'b0;
            torque_limiting_flag <= 1'b0;
        end else begin
            speed_reached_flag <= settled && servo_on && vel_mode && sa_hit; // [R8]
            speed_limiting_flag <= settled && servo_on && trq_mode
                && speed_at_limit;                                      // [R18]
            torque_limiting_flag <= settled && servo_on && !trq_mode
                && torque_at_limit;                                     // [R21]
        end
    end

    // ------------------------------------------------------------
    // Zero speed and brake
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            zero_speed_flag <= 1'b0;
        end else begin
            zero_speed_flag <= zsp_raw;                                 // [R19]
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            brake_interlock_flag <= 1'b0;
        end else begin
            // Brake holds whenever the shaft is not under servo control
            brake_interlock_flag <= settled && servo_on && !alarm_active; // [R17]
        end
    end

    // ------------------------------------------------------------
    // Gain-switch indicators
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gain_switch_indicator        <= 1'b0;
            gain_switch_indicator_second <= 1'b0;
        end else begin
            gain_switch_indicator        <= settled && gain_set1_active; // [R13]
            gain_switch_indicator_second <= settled && gain_set2_active; // [R13]
        end
    end

    // ------------------------------------------------------------
    // Loop and position-state indicators
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            abs_position_lost_flag       <= 1'b0;
            fully_closed_loop_indicator  <= 1'b0;
            tough_drive_flag             <= 1'b0;
        end else begin
            abs_position_lost_flag       <= settled && !abs_pos_valid;   // [R14]
            fully_closed_loop_indicator  <= settled && closed_loop_full; // [R15]
            tough_drive_flag             <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Converter status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            converter_status_flag <= 1'b0;
        end else if (!settled || conv_stop_alarm) begin
            // Stop alarm beats a coincident ready-on: the safe outcome
            converter_status_flag <= 1'b0;                           // [R16]
        end else if (ready_on_rise) begin
            converter_status_flag <= 1'b1;                           // [R16]
        end
    end

endmodule : servo_status_output_flags

// [core/status_flags_pkg.sv]
// Types shared by the servo status output flag logic
package status_flags_pkg;
    typedef enum logic [1:0] {
        MODE_POSITION = 2'b00,
        MODE_VELOCITY = 2'b01,
        MODE_TORQUE   = 2'b10
    } ctrl_mode_t;

    typedef enum logic [1:0] {
        ST_SETTLING = 2'b00,
        ST_RUN      = 2'b01
    } settle_state_t;
endpackage : status_flags_pkg

// [core/status_flags_regs.svh]
// Timing constants and defaults for the servo status output flags
`ifndef STATUS_FLAGS_REGS_SVH
`define STATUS_FLAGS_REGS_SVH

// Control clock rate in kHz
`define CLK_SYS_KHZ           40000
// Power-on settling window, in ms
`define SETTLE_SINGLE_MIN_MS  2500
`define SETTLE_SINGLE_MAX_MS  3500
`define SETTLE_MULTI_MIN_MS   3500
`define SETTLE_MULTI_MAX_MS   4000
// Settling point chosen at the window start, in cycles
`define SETTLE_SINGLE_CYC     (`SETTLE_SINGLE_MIN_MS * `CLK_SYS_KHZ)
`define SETTLE_MULTI_CYC      (`SETTLE_MULTI_MIN_MS * `CLK_SYS_KHZ)
// Speed-reached band: set*5/100 + 20
`define SA_PCT                5
`define SA_OFFSET             20
`define SA_MIN_SET            20
// Zero-speed defaults
`define ZSP_LEVEL_DEFAULT     50
`define ZSP_HYST              20
// Warning codes for battery flag
`define WARN_BATT_CABLE       12'h092
`define WARN_BATT_LOW         12'h09F

`endif

// [core/zero_speed_det.sv]
// Zero-speed detector with hysteresis on speed magnitude
`timescale 1ns/1ps
`include "status_flags_regs.svh"
module zero_speed_det #(
    parameter int SPW = 16
) (
    input  wire logic           clk_sys,
    input  wire logic           rstn,
    input  wire logic           enable,
    input  wire logic [SPW-1:0] speed_mag,
    input  wire logic [SPW-1:0] zero_speed_level_setting,
    output logic                zero_speed
);
    logic [SPW:0] off_level;

    assign off_level = {1'b0, zero_speed_level_setting} + (SPW+1)'(`ZSP_HYST);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            zero_speed <= 1'b0;
        end else if (!enable) begin
            zero_speed <= 1'b0;
        end else if (speed_mag <= zero_speed_level_setting) begin
            zero_speed <= 1'b1;                                   // [R19]
        end else if ({1'b0, speed_mag} >= off_level) begin
            zero_speed <= 1'b0;                                   // [R20]
        end
    end
endmodule : zero_speed_det

// [verif/brake_relay_model.sv]
// Holding brake relay driven from the brake interlock output
`timescale 1ns/1ps
module brake_relay_model (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic brake_interlock_flag,
    output logic      brake_released
);
    // Relay pulls in a cycle late; unpowered it always holds the shaft
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            brake_released <= 1'b0;
        end else begin
            brake_released <= brake_interlock_flag;
        end
    end
endmodule : brake_relay_model

// [verif/servo_status_output_flags_properties.sv]
// Concurrent checks on the servo status flag outputs
`timescale 1ns/1ps
module servo_status_output_flags_properties
    import status_flags_pkg::*;
#(
    parameter int SPW          = 16,
    parameter int DPW          = 24,
    parameter int SETTLE_MULTI = 70
) (
    input wire logic           clk_sys,
    input wire logic           rstn,
    input wire logic [1:0]     ctrl_mode,
    input wire logic           batteryless_abs,
    input wire logic [DPW-1:0] in_position_range_setting,
    input wire logic [SPW-1:0] zero_speed_level_setting,
    input wire logic           base_shutoff,
    input wire logic           alarm_active,
    input wire logic           conv_stop_alarm,
    input wire logic           servo_on,
    input wire logic [DPW-1:0] droop_mag,
    input wire logic [SPW-1:0] speed_mag,
    input wire logic           ready_on_cmd,
    input wire logic           malfunction_flag,
    input wire logic           in_position_flag,
    input wire logic           speed_reached_flag,
    input wire logic           battery_warning_flag,
    input wire logic           converter_status_flag,
    input wire logic           brake_interlock_flag,
    input wire logic           speed_limiting_flag,
    input wire logic           zero_speed_flag,
    input wire logic           torque_limiting_flag
);
    logic [31:0] up_r;
    logic        ok;
    logic        inpos_want;
    // Margin past the longer window, so either axis kind is covered
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            up_r <= '0;
        end else if (up_r < 32'(SETTLE_MULTI + 4)) begin
            up_r <= up_r + 32'h1;
        end
    end
    assign ok         = up_r == 32'(SETTLE_MULTI + 4);
    assign inpos_want = ctrl_mode == MODE_POSITION && droop_mag <= in_position_range_setting;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_slow;
        ok && speed_mag <= zero_speed_level_setting;
    endsequence
    sequence s_cmd;
        ok && $rose(ready_on_cmd) && !conv_stop_alarm ##1 !conv_stop_alarm [*4];
    endsequence
    shutoff_malf_a: assert property (base_shutoff |=> !malfunction_flag)
        else $error("malfunction flag high after shutoff");
    inpos_track_a: assert property (ok |=> in_position_flag == $past(inpos_want))
        else $error("in-position flag wrong");
    sa_gate_a: assert property (
        !servo_on || ctrl_mode != MODE_VELOCITY |=> !speed_reached_flag)
        else $error("speed reached outside velocity servo-on");
    batt_off_a: assert property (batteryless_abs |=> !battery_warning_flag)
        else $error("battery warning with battery-less encoder");
    brake_off_a: assert property (!servo_on || alarm_active |=> !brake_interlock_flag)
        else $error("brake released at servo-off or alarm");
    zsp_on_a: assert property (s_slow |-> ##2 zero_speed_flag)
        else $error("zero speed flag missing");
    zsp_off_a: assert property (
        ok && speed_mag >= zero_speed_level_setting + 20 |-> ##2 !zero_speed_flag)
        else $error("zero speed flag above off level");
    conv_set_a: assert property (s_cmd |-> converter_status_flag)
        else $error("converter flag not set");
    conv_clr_a: assert property (conv_stop_alarm |=> !converter_status_flag)
        else $error("converter flag not cleared");
    tlc_gate_a: assert property (
        !servo_on || ctrl_mode == MODE_TORQUE |=> !torque_limiting_flag)
        else $error("torque limiting flag not gated");
    vlc_gate_a: assert property (
        !servo_on || ctrl_mode != MODE_TORQUE |=> !speed_limiting_flag)
        else $error("speed limiting flag not gated");
endmodule : servo_status_output_flags_properties

// [verif/servo_status_output_flags_tb_top.sv]
// Self-checking bench of the servo status output flags
`timescale 1ns/1ps
module servo_status_output_flags_tb_top
    import status_flags_pkg::*;
;
    logic        clk_sys, rstn, multi_axis, batteryless_abs, base_shutoff, alarm_active;
    logic        conv_stop_alarm, warning_active, stop_warning_active, servo_on;
    logic        speed_at_limit, torque_at_limit, gain_set1_active, gain_set2_active;
    logic        abs_pos_valid, closed_loop_full, ready_on_cmd, brake_released;
    logic [1:0]  ctrl_mode;
    logic [11:0] warning_code;
    logic [15:0] zero_speed_level_setting, set_speed, speed_mag, seed;
    logic [23:0] in_position_range_setting, droop_mag;
    logic        malfunction_flag, in_position_flag, ready_flag, speed_reached_flag;
    logic        warning_flag, battery_warning_flag, motor_stop_warning_flag;
    logic        gain_switch_indicator, gain_switch_indicator_second, abs_position_lost_flag;
    logic        tough_drive_flag, fully_closed_loop_indicator, converter_status_flag;
    logic        brake_interlock_flag, speed_limiting_flag, zero_speed_flag;
    logic        torque_limiting_flag;
    logic [14:0] obs, e;
    int          fails, checked, cyc;
    logic [15:0] sa_set [8] = '{16'h64, 16'h64, 16'h64, 16'h64, 16'h14, 16'h15, 16'h15, 16'h00};
    logic [15:0] sa_spd [8] = '{16'h7D, 16'h7E, 16'h4B, 16'h4A, 16'h1F4, 16'h2A, 16'h2B, 16'h00};
    logic [15:0] zs_spd [8] = '{16'h64, 16'h32, 16'h45, 16'h46, 16'h33, 16'h32, 16'h00, 16'hC8};
    logic [7:0]  zs_exp     = 8'h66;
    assign obs = {malfunction_flag, in_position_flag, ready_flag, speed_reached_flag, warning_flag,
                  battery_warning_flag, motor_stop_warning_flag, gain_switch_indicator,
                  gain_switch_indicator_second, abs_position_lost_flag, tough_drive_flag,
                  fully_closed_loop_indicator, brake_interlock_flag, speed_limiting_flag,
                  torque_limiting_flag};
    // Short settle counts keep the power-on windows inside the run
    servo_status_output_flags #(.SETTLE_SINGLE(50), .SETTLE_MULTI(70)) dut_u (.*);
    brake_relay_model relay_u (.*);
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    // ----
    // Helpers
    // ----
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    function automatic logic [14:0] exp_flags();
        int   band;
        logic sa;
        band = set_speed * 5 / 100 + 20;
        sa   = servo_on && ctrl_mode == MODE_VELOCITY && (set_speed <= 16'h14
               || (int'(speed_mag) >= int'(set_speed) - band && speed_mag <= set_speed + band));
        return {!(base_shutoff || alarm_active),
                ctrl_mode == MODE_POSITION && droop_mag <= in_position_range_setting,
                servo_on, sa, warning_active,
                !batteryless_abs && warning_active && warning_code inside {12'h092, 12'h09F},
                stop_warning_active, gain_set1_active, gain_set2_active, !abs_pos_valid,
                1'b0, closed_loop_full, servo_on && !alarm_active,
                servo_on && ctrl_mode == MODE_TORQUE && speed_at_limit,
                servo_on && ctrl_mode != MODE_TORQUE && torque_at_limit};
    endfunction : exp_flags
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic power_up(input logic ma, input int lo, input int hi);
        @(posedge clk_sys);
        rstn       <= 1'b0;
        multi_axis <= ma;
        tick(8);
        chk("flags in reset", 17'h0, {obs, zero_speed_flag, converter_status_flag});
        @(posedge clk_sys);
        rstn <= 1'b1;
        tick(lo);
        chk("early malfunction", 17'h0, 17'(malfunction_flag));
        tick(hi - lo);
        chk("settled flags", 17'h2, 17'({malfunction_flag, warning_flag}));
    endtask : power_up
    task automatic drive_random();
        logic [15:0] r1, r2, r3;
        r1 = rnd();
        r2 = rnd();
        r3 = rnd();
        ctrl_mode <= (r1[1:0] == 2'b11) ? 2'b01 : r1[1:0];
        {servo_on, base_shutoff, alarm_active} <= {r1[2] | r1[3], r1[4] & r1[5], r1[6] & r1[7]};
        warning_active <= r1[8];
        warning_code   <= r1[8] ? (r1[9] ? 12'h092 : (r1[10] ? 12'h09F : 12'h0E1)) : 12'h000;
        {stop_warning_active, gain_set1_active, gain_set2_active} <= r1[13:11];
        {abs_pos_valid, closed_loop_full} <= r1[15:14];
        {batteryless_abs, speed_at_limit, torque_at_limit} <= r2[2:0];
        droop_mag <= {18'h0, r2[8:3]};
        set_speed <= {8'h00, r3[7:0]};
        speed_mag <= {8'h00, r3[7:0]} + {10'h000, r2[14:9]} - 16'h0020;
    endtask : drive_random
    // ----
    // Scenarios
    // ----
    initial begin
        clk_sys = 1'b0;
        rstn    = 1'b0;
        {multi_axis, batteryless_abs, base_shutoff, alarm_active, conv_stop_alarm} = '0;
        {warning_active, stop_warning_active, servo_on, speed_at_limit, torque_at_limit} = '0;
        {gain_set1_active, gain_set2_active, abs_pos_valid, closed_loop_full} = '0;
        {ready_on_cmd, ctrl_mode, warning_code, set_speed, speed_mag, droop_mag} = '0;
        in_position_range_setting = 24'h000020;
        zero_speed_level_setting  = 16'h0032;
        seed                      = 16'h4D79;
        power_up(1'b0, 40, 60);
        power_up(1'b1, 60, 80);
        repeat (300) begin
            @(posedge clk_sys);
            drive_random();
            tick(1);
            e = exp_flags();
            chk("motion flags", 17'(e[14:11]), 17'(obs[14:11]));
            chk("warning flags", 17'(e[10:8]), 17'(obs[10:8]));
            chk("state flags", 17'(e[7:0]), 17'(obs[7:0]));
        end
        @(posedge clk_sys);
        {servo_on, alarm_active, base_shutoff, ctrl_mode} <= {3'b100, MODE_VELOCITY};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            set_speed <= sa_set[i];
            speed_mag <= sa_spd[i];
            tick(1);
            e = exp_flags();
            chk("speed band", 17'(e[11]), 17'(speed_reached_flag));
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            speed_mag <= zs_spd[i];
            tick(2);
            chk("zero speed", 17'(zs_exp[i]), 17'(zero_speed_flag));
        end
        // Last case raises both at once: the stop must win over the command
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {conv_stop_alarm, ready_on_cmd} <= 2'(8'hC4 >> (2 * i));
            tick(5);
            chk("converter flag", 17'(i == 1 || i == 2), 17'(converter_status_flag));
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            {servo_on, alarm_active} <= {1'b1, i[0]};
            tick(2);
            chk("brake relay", 17'(i == 0), 17'(brake_released));
        end
        close_out();
    end
endmodule : servo_status_output_flags_tb_top
bind servo_status_output_flags servo_status_output_flags_properties #(
    .SPW(SPW), .DPW(DPW), .SETTLE_MULTI(SETTLE_MULTI)) chk_u (.*);
